// File: haptic_gpi_playback_sequencer.sv
// playback state machine of the trigger-driven haptic driver
// Contract
// - boot loads settings before accepting triggers
// - after boot, idle without driving actuator
// - trigger edge from idle starts its sequence
// - leave drive at sequence end or edge
// - any fault aborts playback to idle
// - click: 25ms drive, 10ms brake, 20ms silence
// - strong buzz drives high level up to 60s
// - medium buzz drives lower level up to 60s
// - edge during playback only stops it
// - next edge after stop restarts playback
// - stop edges honoured from 5ms to 60s
// - idle after finish accepts later triggers
// - host runs one 250ms medium calibration pass
// - keep calibration except in OFF
// - cap drive 1.12V below measured supply
// - enable low means OFF; leaving resets
// - no automatic retry after protection stop
`timescale 1ns/100ps
module haptic_gpi_playback_sequencer
	import haptic_pkg::*;
#(
	parameter int BUZZ_MAX_MS = BUZZ_MAX_S * 1000,
	parameter int MS_TICK_CYCLES = MS_CYCLES,
	parameter int BOOT_WAIT_CYCLES = BOOT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable_pin,
	input wire logic click_trigger_input,
	input wire logic strong_buzz_input,
	input wire logic medium_buzz_input,
	input wire logic supply_undervoltage_lockout,
	input wire logic over_temperature,
	input wire logic output_short,
	input wire logic impedance_fault,
	input wire logic [LEVEL_W-1:0] supply_mv,
	output logic [1:0] drive_mode,
	output logic [LEVEL_W-1:0] drive_level,
	output logic in_idle,
	output logic in_drive,
	output logic calibrated,
	output logic fault_abort
);
	typedef enum logic [1:0] {
		ST_OFF,
		ST_BOOT,
		ST_IDLE,
		ST_DRIVE
	} sys_state_t;

	sys_state_t state;
	seq_kind_t kind;
	logic [31:0] boot_cnt;
	logic [31:0] tick_cnt;
	logic ms_tick;
	logic [SEQ_MS_W-1:0] ms_cnt;
	logic seq_done;
	logic fault;
	logic cal_pass;
	logic [LEVEL_W-1:0] next_level;
	drive_mode_t next_mode;

	trigger_if ev ();

	trigger_edges u_edges (
		.clk(clk),
		.rst_n(rst_n),
		.click_trigger_input(click_trigger_input),
		.strong_buzz_input(strong_buzz_input),
		.medium_buzz_input(medium_buzz_input),
		.ev(ev)
	);

	function automatic logic [LEVEL_W-1:0] cap_level(input logic [LEVEL_W-1:0] want,
			input logic [LEVEL_W-1:0] supply);
		logic [LEVEL_W-1:0] room;
		room = (supply > HEADROOM_MV) ? supply - HEADROOM_MV : LEVEL_ZERO;
		cap_level = (want > room) ? room : want;
	endfunction : cap_level

	assign fault = supply_undervoltage_lockout | over_temperature | output_short | impedance_fault;

	// end of the running sequence, in milliseconds since its start
	always_comb begin
		unique case (kind)
			SEQ_CLICK: seq_done = ms_tick && (32'(ms_cnt) + 1 >=
				CLICK_DRIVE_MS + CLICK_BRAKE_MS + CLICK_SILENCE_MS);
			SEQ_STRONG, SEQ_MEDIUM: seq_done = ms_tick && (32'(ms_cnt) + 1 >= BUZZ_MAX_MS);
			SEQ_NONE: seq_done = 1'b0;
		endcase
	end

	// millisecond enable divider, restarted at each sequence start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
		end else if (state != ST_DRIVE || ms_tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1;
		end
	end
	assign ms_tick = (state == ST_DRIVE) && (tick_cnt == 32'(MS_TICK_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= '0;
		end else if (state != ST_DRIVE) begin
			ms_cnt <= '0;
		end else if (ms_tick) begin
			ms_cnt <= ms_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt <= '0;
		end else if (state != ST_BOOT) begin
			boot_cnt <= '0;
		end else begin
			boot_cnt <= boot_cnt + 1;
		end
	end

	// system state machine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
			kind <= SEQ_NONE;
		end else if (!enable_pin) begin
			state <= ST_OFF;
			kind <= SEQ_NONE;
		end else begin
			unique case (state)
				ST_OFF: state <= ST_BOOT;
				ST_BOOT: begin
					if (boot_cnt >= 32'(BOOT_WAIT_CYCLES - 1)) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (ev.any_edge) begin
						state <= ST_DRIVE;
						if (ev.click_edge) begin
							kind <= SEQ_CLICK;
						end else if (ev.strong_edge) begin
							kind <= SEQ_STRONG;
						end else begin
							kind <= SEQ_MEDIUM;
						end
					end
				end
				ST_DRIVE: begin
					if (fault || ev.any_edge || seq_done) begin
						state <= ST_IDLE;
						kind <= SEQ_NONE;
					end
				end
			endcase
		end
	end

	// a medium buzz pass that reaches the calibration time without a fault locks tuning
	assign cal_pass = (state == ST_DRIVE) && (kind == SEQ_MEDIUM) && !fault && ms_tick &&
		(32'(ms_cnt) + 1 == CAL_TIME_MS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			calibrated <= 1'b0;
		end else if (!enable_pin || state == ST_OFF) begin
			calibrated <= 1'b0;
		end else if (cal_pass) begin
			calibrated <= 1'b1;
		end
	end

	// drive phase and amplitude for the running sequence
	always_comb begin
		next_mode = DRV_OFF_MODE;
		next_level = LEVEL_ZERO;
		if (state == ST_DRIVE && enable_pin && !fault && !ev.any_edge && !seq_done) begin
			unique case (kind)
				SEQ_CLICK: begin
					if (32'(ms_cnt) < CLICK_DRIVE_MS) begin
						next_mode = DRV_DRIVE_MODE;
						next_level = cap_level(LEVEL_HIGH_MV, supply_mv);
					end else if (32'(ms_cnt) < CLICK_DRIVE_MS + CLICK_BRAKE_MS) begin
						next_mode = DRV_BRAKE_MODE;
						next_level = cap_level(LEVEL_HIGH_MV, supply_mv);
					end
				end
				SEQ_STRONG: begin
					next_mode = DRV_DRIVE_MODE;
					next_level = cap_level(LEVEL_HIGH_MV, supply_mv);
				end
				SEQ_MEDIUM: begin
					next_mode = DRV_DRIVE_MODE;
					next_level = cap_level(LEVEL_MED_MV, supply_mv);
				end
				SEQ_NONE: begin
					next_mode = DRV_OFF_MODE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_mode <= DRV_OFF_MODE;
			drive_level <= LEVEL_ZERO;
		end else begin
			drive_mode <= next_mode;
			drive_level <= next_level;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_idle <= 1'b0;
			in_drive <= 1'b0;
			fault_abort <= 1'b0;
		end else begin
			in_idle <= enable_pin && ((state == ST_IDLE && !ev.any_edge) || (state == ST_DRIVE &&
				(fault || ev.any_edge || seq_done)) ||
				(state == ST_BOOT && boot_cnt >= 32'(BOOT_WAIT_CYCLES - 1)));
			in_drive <= enable_pin && ((state == ST_DRIVE && !(fault || ev.any_edge || seq_done))
				|| (state == ST_IDLE && ev.any_edge));
			fault_abort <= enable_pin && state == ST_DRIVE && fault;
		end
	end

	// state machine and status flags
	a_boot_blocks_trig: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_BOOT |=> state != ST_DRIVE) else $error("drive entered from boot");
	a_boot_to_idle: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_BOOT && enable_pin && boot_cnt >= 32'(BOOT_WAIT_CYCLES - 1)
		|=> state == ST_IDLE) else $error("boot did not reach idle");
	a_idle_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_IDLE && !ev.any_edge |=> drive_mode == DRV_OFF_MODE)
		else $error("actuator driven in idle");
	a_idle_flag_state: assert property (@(posedge clk) disable iff (!rst_n)
		in_idle == (state == ST_IDLE)) else $error("idle flag disagrees with state");
	a_idle_edge_drive: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_IDLE && enable_pin && ev.any_edge |=> state == ST_DRIVE)
		else $error("trigger from idle ignored");
	a_drive_flag_state: assert property (@(posedge clk) disable iff (!rst_n)
		in_drive == (state == ST_DRIVE)) else $error("drive flag disagrees with state");
	a_flags_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
		!(in_idle && in_drive)) else $error("idle and drive flags both set");
	a_stop_edge_idle: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && enable_pin && ev.any_edge
		|=> state == ST_IDLE && drive_mode == DRV_OFF_MODE)
		else $error("stop edge did not return to idle");
	a_no_retry: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_IDLE && enable_pin && !ev.any_edge |=> state == ST_IDLE)
		else $error("drive without edge");
	a_fault_abort: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && fault |=> state != ST_DRIVE && drive_mode == DRV_OFF_MODE)
		else $error("fault did not abort playback");
	a_fault_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && enable_pin && fault |=> fault_abort ##1 !fault_abort)
		else $error("fault report not a single pulse");

	// sequence timing and drive level
	a_click_drive_phase: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && enable_pin && kind == SEQ_CLICK && !fault && !ev.any_edge
		&& ms_cnt < SEQ_MS_W'(CLICK_DRIVE_MS) |=> drive_mode == DRV_DRIVE_MODE)
		else $error("click drive missing");
	a_click_brake_phase: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && enable_pin && kind == SEQ_CLICK && !fault && !ev.any_edge
		&& ms_cnt == SEQ_MS_W'(CLICK_DRIVE_MS) |=> drive_mode == DRV_BRAKE_MODE)
		else $error("click brake missing");
	a_click_silence: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && kind == SEQ_CLICK
		&& ms_cnt >= SEQ_MS_W'(CLICK_DRIVE_MS + CLICK_BRAKE_MS) |=> drive_mode == DRV_OFF_MODE)
		else $error("click silence driven");
	a_buzz_timeout: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && kind != SEQ_CLICK |-> 32'(ms_cnt) < BUZZ_MAX_MS)
		else $error("buzz ran past its limit");
	a_strong_level: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && enable_pin && kind == SEQ_STRONG && !fault && !ev.any_edge
		&& !seq_done |=> drive_mode == DRV_DRIVE_MODE
		&& drive_level == cap_level(LEVEL_HIGH_MV, $past(supply_mv)))
		else $error("strong level wrong");
	a_medium_level: assert property (@(posedge clk) disable iff (!rst_n)
		drive_mode == DRV_DRIVE_MODE && $past(kind) == SEQ_MEDIUM
		|-> drive_level == cap_level(LEVEL_MED_MV, $past(supply_mv)))
		else $error("medium level wrong");
	a_level_capped: assert property (@(posedge clk) disable iff (!rst_n)
		drive_mode != DRV_OFF_MODE |-> drive_level == LEVEL_ZERO
		|| 32'(drive_level) + 32'(HEADROOM_MV) <= 32'($past(supply_mv)))
		else $error("drive above supply headroom");

	// calibration and enable
	a_cal_needs_pass: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(calibrated) |-> $past(state) == ST_DRIVE && $past(kind) == SEQ_MEDIUM)
		else $error("calibration set outside a medium pass");
	a_off_clears_cal: assert property (@(posedge clk) disable iff (!rst_n)
		!enable_pin |=> !calibrated && state == ST_OFF) else $error("off kept state");
	a_off_to_boot: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_OFF && enable_pin |=> state == ST_BOOT) else $error("no boot after off");

	c_click_done: cover property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && kind == SEQ_CLICK && seq_done);
	c_stop_edge: cover property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && ev.any_edge);
	c_calibrated: cover property (@(posedge clk) disable iff (!rst_n) $rose(calibrated));
	c_fault_stop: cover property (@(posedge clk) disable iff (!rst_n) state == ST_DRIVE && fault);
	c_buzz_timeout: cover property (@(posedge clk) disable iff (!rst_n)
		state == ST_DRIVE && kind == SEQ_MEDIUM && seq_done);
endmodule : haptic_gpi_playback_sequencer

// File: haptic_gpi_playback_sequencer_tb.sv
// self-checking bench for the haptic playback sequencer
`timescale 1ns/100ps
module haptic_gpi_playback_sequencer_tb;
	import haptic_pkg::*;
	localparam int MS = 10;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic enable_pin = 1'b0;
	logic req = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [3:0] faults = 4'h0;
	logic [LEVEL_W-1:0] supply_mv = 12'hC80;
	logic click_pin, strong_pin, medium_pin, host_busy, in_idle, in_drive, calibrated;
	logic fault_abort;
	logic [1:0] drive_mode;
	logic [LEVEL_W-1:0] drive_level;
	int err_total = 0;
	int checked = 0;
	int seed = 32'hd964;
	int gap;
	int t;
	int offs[6] = '{6, 230, 280, 330, 380, 500};
	logic [1:0] modes[6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
	always #20 clk = ~clk;
	host_gpio_model host (.clk(clk), .req(req), .sel(sel), .click_pin(click_pin),
		.strong_pin(strong_pin), .medium_pin(medium_pin), .busy(host_busy));
	haptic_gpi_playback_sequencer #(.BUZZ_MAX_MS(300), .MS_TICK_CYCLES(MS),
		.BOOT_WAIT_CYCLES(5)) uut (.clk(clk), .rst_n(rst_n), .enable_pin(enable_pin),
		.click_trigger_input(click_pin), .strong_buzz_input(strong_pin),
		.medium_buzz_input(medium_pin), .supply_undervoltage_lockout(faults[0]),
		.over_temperature(faults[1]), .output_short(faults[2]), .impedance_fault(faults[3]),
		.supply_mv(supply_mv), .drive_mode(drive_mode), .drive_level(drive_level),
		.in_idle(in_idle), .in_drive(in_drive), .calibrated(calibrated),
		.fault_abort(fault_abort));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic fire(input logic [1:0] s);
		for (int i = 0; i < 2000 && host_busy; i++) cyc(1);
		sel = s;
		req = 1'b1;
		cyc(1);
		req = 1'b0;
	endtask : fire
	task automatic wait_idle();
		for (int i = 0; i < 60 && in_idle !== 1'b1; i++) cyc(1);
	endtask : wait_idle
	function automatic logic [11:0] exp_level(input logic [11:0] nom, input logic [11:0] sup);
		logic [11:0] cap;
		cap = (sup > HEADROOM_MV) ? sup - HEADROOM_MV : LEVEL_ZERO;
		return (cap < nom) ? cap : nom;
	endfunction : exp_level
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		#(40 * 60000);
		err_total++;
		complete_run();
	end
	initial begin
		cyc(12);
		rst_n = 1'b1;
		fire(2'h1);
		cyc(10);
		enable_pin = 1'b1;
		wait_idle();
		chk("idle_after_boot", 1'b1, in_idle);
		chk("no_drive_in_idle", 1'b0, in_drive);
		chk("idle_mode", DRV_OFF_MODE, drive_mode);
		fire(2'h0);
		t = 0;
		for (int i = 0; i < 6; i++) begin
			cyc(offs[i] - t);
			t = offs[i];
			chk("click_mode", modes[i], drive_mode);
			if (modes[i] != 2'h0) begin
				chk("click_level", exp_level(LEVEL_HIGH_MV, supply_mv), drive_level);
			end
		end
		cyc(100);
		chk("click_end", 1'b1, in_idle);
		for (int k = 1; k < 3; k++) begin
			supply_mv = 12'($random(seed));
			gap = 20 + ($unsigned($random(seed)) % 1500);
			fire(2'(k));
			cyc(6);
			chk("buzz_level", exp_level(k == 1 ? LEVEL_HIGH_MV : LEVEL_MED_MV, supply_mv),
				drive_level);
			for (int i = 0; i < 2000 && host_busy; i++) cyc(1);
			cyc(gap);
			chk("one_edge_one_start", 1'b1, in_drive);
			fire(k == 1 ? 2'h2 : 2'h0);
			cyc(6);
			chk("stop_idle", 1'b1, in_idle);
			chk("stop_mode", DRV_OFF_MODE, drive_mode);
		end
		chk("not_calibrated", 1'b0, calibrated);
		supply_mv = 12'hFFF;
		fire(2'h2);
		cyc(6);
		chk("restart_drive", 1'b1, in_drive);
		chk("medium_level", LEVEL_MED_MV, drive_level);
		cyc(2700);
		chk("calibrated", 1'b1, calibrated);
		chk("medium_running", DRV_DRIVE_MODE, drive_mode);
		cyc(400);
		chk("buzz_timeout", 1'b1, in_idle);
		for (int f = 0; f < 4; f++) begin
			supply_mv = (f == 0) ? 12'h460 : 12'h9C4;
			fire(2'h1);
			cyc(6);
			chk("retrigger", 1'b1, in_drive);
			chk("capped_level", exp_level(LEVEL_HIGH_MV, supply_mv), drive_level);
			cyc(20);
			faults = 4'h1 << f;
			cyc(1);
			chk("fault_abort", 1'b1, fault_abort);
			cyc(3);
			chk("fault_idle", 1'b1, in_idle);
			chk("fault_pulse_end", 1'b0, fault_abort);
			cyc(40);
			faults = 4'h0;
			cyc(40);
			chk("no_retry", 1'b0, in_drive);
		end
		chk("cal_kept", 1'b1, calibrated);
		fire(2'h1);
		cyc(20);
		enable_pin = 1'b0;
		cyc(4);
		chk("off_no_drive", 1'b0, in_drive);
		chk("off_cal_lost", 1'b0, calibrated);
		enable_pin = 1'b1;
		wait_idle();
		chk("reboot_idle", 1'b1, in_idle);
		complete_run();
	end
endmodule : haptic_gpi_playback_sequencer_tb

// File: haptic_pkg.sv
// constants and types shared by the haptic playback sequencer
package haptic_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int BOOT_TIME_US = 100;
	localparam int CLICK_DRIVE_MS = 25;
	localparam int CLICK_BRAKE_MS = 10;
	localparam int CLICK_SILENCE_MS = 20;
	localparam int BUZZ_MAX_S = 60;
	localparam int CAL_TIME_MS = 250;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int BOOT_CYCLES = (CLK_HZ / 1000000) * BOOT_TIME_US;
	localparam int LEVEL_W = 12;
	localparam logic [11:0] LEVEL_HIGH_MV = 12'h708;
	localparam logic [11:0] LEVEL_MED_MV = 12'h3E8;
	localparam logic [11:0] HEADROOM_MV = 12'h460;
	localparam logic [11:0] LEVEL_ZERO = 12'h000;
	localparam int SEQ_MS_W = 17;
	typedef enum logic [1:0] {
		DRV_OFF_MODE,
		DRV_DRIVE_MODE,
		DRV_BRAKE_MODE
	} drive_mode_t;
	typedef enum logic [1:0] {
		SEQ_NONE,
		SEQ_CLICK,
		SEQ_STRONG,
		SEQ_MEDIUM
	} seq_kind_t;
endpackage : haptic_pkg

// File: host_gpio_model.sv
// host side model: one falling trigger pulse per request, pins idle high
`timescale 1ns/100ps
module host_gpio_model #(
	parameter int PULSE_CYCLES = 630
) (
	input wire logic clk,
	input wire logic req,
	input wire logic [1:0] sel,
	output logic click_pin,
	output logic strong_pin,
	output logic medium_pin,
	output logic busy
);
	logic [2:0] pins = 3'h7;
	int cnt = 0;
	assign {medium_pin, strong_pin, click_pin} = pins;
	assign busy = (cnt != 0);
	// low time stays above 25 us at 40 ns a cycle, then 20 cycles high before the next pulse
	always @(posedge clk) begin
		if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == 20) begin
				pins <= 3'h7;
			end
		end else if (req) begin
			pins <= ~(3'h1 << sel);
			cnt <= PULSE_CYCLES + 20;
		end
	end
endmodule : host_gpio_model

// File: trigger_edges.sv
// synchronisers and falling edge detectors for the three trigger inputs
`timescale 1ns/100ps
module trigger_edges (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic click_trigger_input,
	input wire logic strong_buzz_input,
	input wire logic medium_buzz_input,
	trigger_if.source ev
);
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] prev;
	logic [2:0] fall;

	// inputs idle high; reset values avoid a false edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 3'h7;
			sync_b <= 3'h7;
			prev <= 3'h7;
		end else begin
			sync_a <= {medium_buzz_input, strong_buzz_input, click_trigger_input};
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	assign fall = prev & ~sync_b;
	assign ev.click_edge = fall[0];
	assign ev.strong_edge = fall[1];
	assign ev.medium_edge = fall[2];
	assign ev.any_edge = |fall;

	a_edge_single_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		fall[0] |=> !fall[0]) else $error("trigger edge lasted two cycles");
	a_edge_from_sync: assert property (@(posedge clk) disable iff (!rst_n)
		fall[1] |-> $past(strong_buzz_input, 3) && !$past(strong_buzz_input, 2))
		else $error("edge without a fall on the pin");
endmodule : trigger_edges

// File: trigger_if.sv
// trigger event bundle between the edge detector and the sequencer
`timescale 1ns/100ps
interface trigger_if;
	logic click_edge;
	logic strong_edge;
	logic medium_edge;
	logic any_edge;
	modport source (output click_edge, output strong_edge, output medium_edge, output any_edge);
	modport sink (input click_edge, input strong_edge, input medium_edge, input any_edge);
endinterface : trigger_if
